// ===== logic/srb_buffer.sv
// Sequential random access buffer: array, pointer, registers
`timescale 1ns/1ps
module srb_buffer (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [11:0] i_random_addr,
  input  wire logic [15:0] i_random_data_bus,
  output wire logic [15:0] o_random_data_bus,
  output wire logic [1:0]  o_random_data_bus_oe_n,
  input  wire logic        i_random_select_n,
  input  wire logic        i_register_select_n,
  input  wire logic        i_random_write_not_read,
  input  wire logic        i_random_output_enable_n,
  input  wire logic        i_low_byte_enable_n,
  input  wire logic        i_high_byte_enable_n,
  input  wire logic        i_seq_clk,
  input  wire logic [15:0] i_seq_data_bus,
  output wire logic [15:0] o_seq_data_bus,
  output wire logic        o_seq_data_bus_oe_n,
  input  wire logic        i_seq_port_select_n,
  input  wire logic        i_pointer_advance_n,
  input  wire logic        i_seq_write_not_read,
  input  wire logic        i_pointer_load_n,
  input  wire logic        i_start_reload_1_n,
  input  wire logic        i_start_reload_2_n,
  output wire logic        o_end_of_region_1_n,
  output wire logic        o_end_of_region_2_n,
  input  wire logic        i_seq_output_drive_n
);

  srb_pkg::srb_rnd_s rnd_m_r;
  srb_pkg::srb_rnd_s rnd_r;
  srb_pkg::srb_seq_s seq_m_r;
  srb_pkg::srb_seq_s seq_r;
  logic              seq_clk_d_r;
  logic              seq_edge;
  logic              seq_wr;
  logic              seq_active_r;
  logic              seq_read_r;
  logic              seq_oe_n_r;
  logic              rnd_arr;
  logic              rnd_reg;
  logic              rnd_arr_wr;
  logic              rnd_reg_wr;
  logic [1:0]        rnd_byte_on;
  logic [11:0]       ptr_r;
  logic [11:0]       ptr_inc;
  logic [11:0]       din_r;
  logic              load_pend_r;
  logic              adv_now;
  logic [11:0]       ctrl_r;
  logic [11:0]       reg_rd;
  logic [15:0]       reg_word;
  wire  [11:0]       start_w [0:1];
  wire  [11:0]       end_w [0:1];
  wire  [1:0]        eob_n_w;
  wire  [15:0]       rnd_q_w;
  wire  [15:0]       seq_q_w;
  wire  [1:0]        rnd_oe_w;

  // Pins are asynchronous; idle values keep a reset from faking a clock edge
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rnd_m_r <= srb_pkg::SRB_RND_IDLE;
      rnd_r   <= srb_pkg::SRB_RND_IDLE;
    end else begin
      rnd_m_r <= '{i_random_addr, i_random_data_bus, i_random_select_n, i_register_select_n,
                   i_random_write_not_read, i_random_output_enable_n, i_low_byte_enable_n,
                   i_high_byte_enable_n};
      rnd_r   <= rnd_m_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      seq_m_r     <= srb_pkg::SRB_SEQ_IDLE;
      seq_r       <= srb_pkg::SRB_SEQ_IDLE;
      seq_clk_d_r <= 1'b1;
    end else begin
      seq_m_r     <= '{i_seq_clk, i_seq_data_bus, i_seq_port_select_n, i_pointer_advance_n,
                       i_seq_write_not_read, i_pointer_load_n, i_start_reload_1_n,
                       i_start_reload_2_n, i_seq_output_drive_n};
      seq_r       <= seq_m_r;
      seq_clk_d_r <= seq_r.clk;
    end
  end

  // Both selects low is illegal; neither path is opened then
  assign rnd_arr     = !rnd_r.sel_n && rnd_r.reg_n;  // RULE2 RULE5
  assign rnd_reg     = rnd_r.sel_n && !rnd_r.reg_n;  // RULE3 RULE4
  assign rnd_arr_wr  = rnd_arr && !rnd_r.wnr;        // RULE5
  assign rnd_reg_wr  = rnd_reg && !rnd_r.wnr;        // RULE4
  assign rnd_byte_on = ~{rnd_r.ub_n, rnd_r.lb_n};    // RULE7

  assign seq_edge = seq_r.clk && !seq_clk_d_r;                       // RULE8
  assign seq_wr   = seq_edge && !seq_r.sel_n && !seq_r.wnr;          // RULE11
  assign ptr_inc  = ptr_r + srb_pkg::SRB_PTR_ONE;                    // RULE20
  assign adv_now  = seq_edge && !load_pend_r && seq_r.strt1_n && seq_r.strt2_n && !seq_r.adv_n;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      seq_active_r <= 1'b0;
      seq_read_r   <= 1'b0;
    end else if (seq_edge) begin
      seq_active_r <= !seq_r.sel_n;                                  // RULE10
      seq_read_r   <= !seq_r.sel_n && seq_r.wnr && !seq_r.oe_n;      // RULE12
    end
  end

  // Output enable follows the pin every cycle, not the port clock
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      seq_oe_n_r <= 1'b1;
    end else begin
      seq_oe_n_r <= !(seq_active_r && seq_read_r && !seq_r.oe_n);   // RULE18 RULE10
    end
  end

  // Pending load outranks reloads, reloads outrank advance
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ptr_r       <= srb_pkg::SRB_PTR_RST;                           // RULE19
      din_r       <= srb_pkg::SRB_REG_RST;
      load_pend_r <= 1'b0;
    end else if (seq_edge) begin
      load_pend_r <= !seq_r.load_n;                                  // RULE13
      if (!seq_r.load_n) begin
        din_r <= seq_r.data[11:0];                                   // RULE13
      end
      if (load_pend_r) begin
        ptr_r <= din_r;                                              // RULE13 RULE15
      end else if (!seq_r.strt1_n) begin
        ptr_r <= start_w[0];                                         // RULE14
      end else if (!seq_r.strt2_n) begin
        ptr_r <= start_w[1];                                         // RULE14
      end else if (!seq_r.adv_n) begin
        ptr_r <= ptr_inc;                                            // RULE9 RULE20
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl_r <= srb_pkg::SRB_CTRL_RST;                               // RULE19
    end else if (rnd_reg_wr && rnd_r.addr[2:0] == srb_pkg::SRB_OFS_CTRL) begin
      ctrl_r <= rnd_r.data[11:0];                                    // RULE4
    end
  end

  always_comb begin
    reg_rd = srb_pkg::SRB_REG_RST;
    case (rnd_r.addr[2:0])
      srb_pkg::SRB_OFS_START1: reg_rd = start_w[0];
      srb_pkg::SRB_OFS_END1:   reg_rd = end_w[0];
      srb_pkg::SRB_OFS_START2: reg_rd = start_w[1];
      srb_pkg::SRB_OFS_END2:   reg_rd = end_w[1];
      srb_pkg::SRB_OFS_FLAGS:  reg_rd = {10'h000, ~eob_n_w};
      srb_pkg::SRB_OFS_CTRL:   reg_rd = ctrl_r;
      default:                 reg_rd = srb_pkg::SRB_REG_RST;
    endcase
  end
  assign reg_word = {4'h0, reg_rd};

  for (genvar k = 0; k < srb_pkg::SRB_REGIONS; k++) begin : g_region
    localparam logic [2:0] OFS_S = (k == 0) ? srb_pkg::SRB_OFS_START1 : srb_pkg::SRB_OFS_START2;
    localparam logic [2:0] OFS_E = (k == 0) ? srb_pkg::SRB_OFS_END1 : srb_pkg::SRB_OFS_END2;
    logic [11:0] start_r;
    logic [11:0] end_r;
    logic        eob_n_r;
    logic        hit;
    logic        clr;

    assign hit = adv_now && (ptr_inc == end_r);                      // RULE16
    assign clr = rnd_reg_wr && rnd_r.addr[2:0] == srb_pkg::SRB_OFS_CTRL && !rnd_r.data[k];

    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        start_r <= srb_pkg::SRB_REG_RST;                             // RULE19
        end_r   <= srb_pkg::SRB_REG_RST;
      end else if (rnd_reg_wr) begin
        if (rnd_r.addr[2:0] == OFS_S) begin
          start_r <= rnd_r.data[11:0];                               // RULE4
        end
        if (rnd_r.addr[2:0] == OFS_E) begin
          end_r <= rnd_r.data[11:0];                                 // RULE4
        end
      end
    end

    // A match in the clearing cycle keeps the flag low
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        eob_n_r <= 1'b1;                                             // RULE19
      end else if (hit) begin
        eob_n_r <= 1'b0;                                             // RULE16
      end else if (clr) begin
        eob_n_r <= 1'b1;                                             // RULE17
      end
    end

    assign start_w[k]  = start_r;
    assign end_w[k]    = end_r;
    assign eob_n_w[k]  = eob_n_r;
  end

  for (genvar b = 0; b < srb_pkg::SRB_BYTES; b++) begin : g_lane
    logic [7:0] mem [srb_pkg::SRB_DEPTH];                            // RULE1
    logic [7:0] rnd_q_r;
    logic [7:0] seq_q_r;
    logic       oe_n_r;

    // Same-word collision: the sequential write is last and wins
    always_ff @(posedge i_ref_clk) begin
      if (rnd_arr_wr && rnd_byte_on[b]) begin
        mem[rnd_r.addr] <= rnd_r.data[b*8 +: 8];                     // RULE5 RULE7
      end
      if (seq_wr) begin
        mem[ptr_r] <= seq_r.data[b*8 +: 8];                          // RULE11
      end
    end

    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        rnd_q_r <= 8'h00;
        seq_q_r <= 8'h00;
      end else begin
        rnd_q_r <= rnd_reg ? reg_word[b*8 +: 8] : mem[rnd_r.addr];   // RULE4 RULE5
        seq_q_r <= mem[ptr_r];                                       // RULE12
      end
    end

    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        oe_n_r <= 1'b1;
      end else begin
        oe_n_r <= !((rnd_arr || rnd_reg) && rnd_r.wnr && !rnd_r.oe_n && rnd_byte_on[b]);  // RULE2 RULE6 RULE7
      end
    end

    assign rnd_q_w[b*8 +: 8] = rnd_q_r;
    assign seq_q_w[b*8 +: 8] = seq_q_r;
    assign rnd_oe_w[b]       = oe_n_r;
  end

  assign o_random_data_bus      = rnd_q_w;
  assign o_random_data_bus_oe_n = rnd_oe_w;
  assign o_seq_data_bus         = seq_q_w;
  assign o_seq_data_bus_oe_n    = seq_oe_n_r;
  assign o_end_of_region_1_n    = eob_n_w[0];
  assign o_end_of_region_2_n    = eob_n_w[1];

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_reset_state: assert property (disable iff (1'b0) i_rst |=> ptr_r == 12'h000 && (&eob_n_w))  // RULE19
    else $error("reset left pointer or flags wrong");
  a_rnd_float: assert property (rnd_r.sel_n && rnd_r.reg_n |=> (&rnd_oe_w))  // RULE2
    else $error("random bus driven while deselected");
  a_rnd_byte_gate: assert property (rnd_arr && rnd_r.wnr && !rnd_r.oe_n |=> rnd_oe_w == ~$past(rnd_byte_on))  // RULE7
    else $error("byte drive does not follow byte enables");
  a_seq_float: assert property (seq_r.oe_n |=> o_seq_data_bus_oe_n)  // RULE18
    else $error("sequential bus driven with enable high");
  a_seq_disable: assert property (seq_edge && seq_r.sel_n |=> !seq_active_r ##1 o_seq_data_bus_oe_n)  // RULE10
    else $error("sequential port not powered down");
  a_ptr_advance: assert property (adv_now |=> ptr_r == $past(ptr_r) + 12'h001)  // RULE9
    else $error("pointer did not advance by one");
  a_din_capture: assert property (seq_edge && !seq_r.load_n |=> din_r == $past(seq_r.data[11:0]))  // RULE13
    else $error("load data not captured");
  a_ptr_load: assert property (seq_edge && load_pend_r  // RULE13
    |=> ptr_r == $past(din_r) && load_pend_r != $past(seq_r.load_n))
    else $error("pointer did not take loaded value");
  a_ptr_reload: assert property (seq_edge && !load_pend_r && !seq_r.strt1_n |=> ptr_r == $past(start_w[0]))  // RULE14
    else $error("start reload one failed");
  a_flag_match: assert property (g_region[0].hit |=> !o_end_of_region_1_n)  // RULE16
    else $error("end flag one not lowered on match");
  a_flag_clear: assert property (g_region[1].clr && !g_region[1].hit |=> o_end_of_region_2_n)  // RULE17
    else $error("end flag two not cleared");
  a_seq_write: assert property (seq_wr |=> g_lane[1].mem[$past(ptr_r)] == $past(seq_r.data[15:8]))  // RULE11
    else $error("sequential write lost");
  a_flag2_match: assert property (g_region[1].hit |=> !o_end_of_region_2_n)  // RULE16
    else $error("end flag two not lowered on match");
  a_flag1_clear: assert property (g_region[0].clr && !g_region[0].hit |=> o_end_of_region_1_n)  // RULE17
    else $error("end flag one not cleared");
  a_ptr_wrap: assert property (adv_now && (&ptr_r) |=> ptr_r == srb_pkg::SRB_PTR_RST)  // RULE20
    else $error("pointer did not wrap to zero");
  a_ctrl_write: assert property (rnd_reg_wr && rnd_r.addr[2:0] == srb_pkg::SRB_OFS_CTRL  // RULE4
    |=> ctrl_r == $past(rnd_r.data[11:0]))
    else $error("control register write lost");
  a_seq_armed: assert property (seq_edge && !seq_r.sel_n && seq_r.wnr && !seq_r.oe_n  // RULE12
    |=> seq_active_r && seq_read_r)
    else $error("sequential read cycle not started");
  // Skipped on a collision, where the sequential write wins the word
  a_rnd_write: assert property (rnd_arr_wr && rnd_byte_on[0] && !(seq_wr && ptr_r == rnd_r.addr)  // RULE5
    |=> g_lane[0].mem[$past(rnd_r.addr)] == $past(rnd_r.data[7:0]))
    else $error("random write lost");

  // Each cover marks a scenario the bench must reach
  c_ptr_load: cover property (seq_edge && load_pend_r);
  c_flag1_hit: cover property (g_region[0].hit);
  c_flag_hit: cover property (g_region[1].hit);
  c_seq_write: cover property (seq_wr);
  c_ctrl_write: cover property (rnd_reg_wr && rnd_r.addr[2:0] == srb_pkg::SRB_OFS_CTRL);

endmodule : srb_buffer

// ===== logic/srb_pkg.sv
// Constants and carriers for the sequential random access buffer
//Contract
//[RULE1] 4096 words of 16 bits, 12-bit address
//[RULE2] Random select high floats bus, keeps data
//[RULE3] Host never lowers both selects together
//[RULE4] Register select reaches registers via low bits
//[RULE5] Random select: write low, read high
//[RULE6] Random bus drives only on read enable
//[RULE7] Byte enables gate each byte independently
//[RULE8] Sequential inputs registered on clock rise
//[RULE9] Pointer advances when advance input low
//[RULE10] Sampled select enables or floats port
//[RULE11] Write cycle when select, direction low
//[RULE12] Read cycle needs output enable low too
//[RULE13] Load captures data, pointer follows next cycle
//[RULE14] Start reload copies start register to pointer
//[RULE15] Controller keeps reloads high around load
//[RULE16] Flag low when pointer reaches end register
//[RULE17] Flags cleared by reset or control zero
//[RULE18] Sequential output enable acts without clock
//[RULE19] Reset clears registers, pointer, raises flags
//[RULE20] Pointer wraps past top to zero
package srb_pkg;
  localparam int SRB_ADDR_W  = 12;
  localparam int SRB_DATA_W  = 16;
  localparam int SRB_DEPTH   = 4096;
  localparam int SRB_REG_W   = 12;
  localparam int SRB_BYTES   = 2;
  localparam int SRB_REGIONS = 2;

  localparam logic [2:0] SRB_OFS_START1 = 3'h0;
  localparam logic [2:0] SRB_OFS_END1   = 3'h1;
  localparam logic [2:0] SRB_OFS_START2 = 3'h2;
  localparam logic [2:0] SRB_OFS_END2   = 3'h3;
  localparam logic [2:0] SRB_OFS_FLAGS  = 3'h4;
  localparam logic [2:0] SRB_OFS_CTRL   = 3'h5;

  localparam logic [11:0] SRB_PTR_RST  = 12'h000;
  localparam logic [11:0] SRB_REG_RST  = 12'h000;
  localparam logic [11:0] SRB_CTRL_RST = 12'h000;
  localparam logic [11:0] SRB_PTR_ONE  = 12'h001;

  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] data;
    logic        sel_n;
    logic        reg_n;
    logic        wnr;
    logic        oe_n;
    logic        lb_n;
    logic        ub_n;
  } srb_rnd_s;

  typedef struct packed {
    logic        clk;
    logic [15:0] data;
    logic        sel_n;
    logic        adv_n;
    logic        wnr;
    logic        load_n;
    logic        strt1_n;
    logic        strt2_n;
    logic        oe_n;
  } srb_seq_s;

  localparam srb_rnd_s SRB_RND_IDLE = '1;
  localparam srb_seq_s SRB_SEQ_IDLE = '1;
endpackage : srb_pkg

// ===== tb/srb_seq_model.sv
// Sequential-side controller model that frames the port clock
`timescale 1ns/1ps
module srb_seq_model (
  input  wire logic        i_ref_clk,
  output srb_pkg::srb_seq_s o_seq
);
  initial begin
    o_seq = srb_pkg::SRB_SEQ_IDLE;
    o_seq.clk = 1'b0;
  end

  // Clock stands low between frames; ctl = sel, adv, wnr, load, reload1, reload2
  task automatic pulse(input logic [5:0] ctl, input logic [15:0] d);
    @(posedge i_ref_clk);
    {o_seq.sel_n, o_seq.adv_n, o_seq.wnr, o_seq.load_n, o_seq.strt1_n, o_seq.strt2_n} <= ctl;
    o_seq.data <= d;
    repeat (4) @(posedge i_ref_clk);
    o_seq.clk <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    o_seq.clk <= 1'b0;
    // Reloads idle high outside frames, so never near a load
    {o_seq.sel_n, o_seq.adv_n, o_seq.wnr, o_seq.load_n, o_seq.strt1_n, o_seq.strt2_n} <= 6'h3F;
    // Released bus shows the inverse, never the stale value
    o_seq.data <= ~d;
    repeat (6) @(posedge i_ref_clk);
    #1;
  endtask : pulse

  task automatic drive_out(input logic oe_n);
    @(posedge i_ref_clk);
    o_seq.oe_n <= oe_n;
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask : drive_out
endmodule : srb_seq_model

// ===== tb/srb_buffer_test.sv
// Self-checking bench for the sequential random access buffer
`timescale 1ns/1ps
module srb_buffer_test;
  // Host controls: sel, reg, wnr, oe, lb, ub
  localparam logic [5:0] WR  = 6'b010100;
  localparam logic [5:0] RD  = 6'b011000;
  localparam logic [5:0] RWR = 6'b100100;
  localparam logic [5:0] RRD = 6'b101000;
  logic              i_ref_clk = 1'b0;
  logic              i_rst     = 1'b1;
  srb_pkg::srb_rnd_s rnd       = srb_pkg::SRB_RND_IDLE;
  srb_pkg::srb_seq_s sq;
  logic [15:0]       rdq;
  logic [1:0]        rdq_oe_n;
  logic [15:0]       sdq;
  logic              sdq_oe_n;
  logic              eor1_n;
  logic              eor2_n;
  logic [15:0]       rdata;
  logic [1:0]        roe;
  int                bad_count = 0;
  int                num_checks = 0;

  initial begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  srb_seq_model ctrl (.i_ref_clk(i_ref_clk), .o_seq(sq));

  srb_buffer dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_random_addr(rnd.addr), .i_random_data_bus(rnd.data),
    .o_random_data_bus(rdq), .o_random_data_bus_oe_n(rdq_oe_n),
    .i_random_select_n(rnd.sel_n), .i_register_select_n(rnd.reg_n),
    .i_random_write_not_read(rnd.wnr), .i_random_output_enable_n(rnd.oe_n),
    .i_low_byte_enable_n(rnd.lb_n), .i_high_byte_enable_n(rnd.ub_n),
    .i_seq_clk(sq.clk), .i_seq_data_bus(sq.data),
    .o_seq_data_bus(sdq), .o_seq_data_bus_oe_n(sdq_oe_n),
    .i_seq_port_select_n(sq.sel_n), .i_pointer_advance_n(sq.adv_n),
    .i_seq_write_not_read(sq.wnr), .i_pointer_load_n(sq.load_n),
    .i_start_reload_1_n(sq.strt1_n), .i_start_reload_2_n(sq.strt2_n),
    .o_end_of_region_1_n(eor1_n), .o_end_of_region_2_n(eor2_n),
    .i_seq_output_drive_n(sq.oe_n)
  );

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // Held four clocks, one more than the two pin synchroniser stages plus the output register need
  task automatic host(input logic [5:0] ctl, input logic [11:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    {rnd.sel_n, rnd.reg_n, rnd.wnr, rnd.oe_n, rnd.lb_n, rnd.ub_n} <= ctl;
    rnd.addr <= a;
    rnd.data <= d;
    repeat (4) @(posedge i_ref_clk);
    #1;
    rdata = rdq;
    roe = rdq_oe_n;
    @(posedge i_ref_clk);
    {rnd.sel_n, rnd.reg_n, rnd.wnr, rnd.oe_n, rnd.lb_n, rnd.ub_n} <= 6'h3F;
    rnd.data <= ~d;
    #1;
  endtask : host

  task automatic do_reset();
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask : do_reset

  task automatic t_reset();
    chk("flag1", 16'h0001, 16'(eor1_n));
    chk("flag2", 16'h0001, 16'(eor2_n));
    chk("seq_oe", 16'h0001, 16'(sdq_oe_n));
    host(RRD, 12'h005, 16'h0000);
    chk("ctrl_rst", 16'h0000, rdata);
  endtask : t_reset

  task automatic t_array();
    for (int i = 0; i < 4; i++) host(WR, 12'(i), 16'hC000 + 16'(i));
    host(WR, 12'hFFF, 16'hA5C3);
    host(6'b010101, 12'hFFF, 16'h0011);
    host(RD, 12'hFFF, 16'h0000);
    chk("word", 16'hA511, rdata);
    chk("word_oe", 16'h0000, 16'(roe));
    host(6'b011001, 12'hFFF, 16'h0000);
    chk("byte_oe", 16'h0002, 16'(roe));
    host(6'b011100, 12'hFFF, 16'h0000);
    chk("oe_off", 16'h0003, 16'(roe));
    host(6'b111000, 12'hFFF, 16'h0000);
    chk("desel", 16'h0003, 16'(roe));
  endtask : t_array

  task automatic t_regs();
    host(RWR, 12'h001, 16'h0003);
    host(RWR, 12'h003, 16'h0001);
    host(RWR, 12'h002, 16'h0002);
    host(RWR, 12'h006, 16'h0FFF);
    host(RRD, 12'h001, 16'h0000);
    chk("end1", 16'h0003, rdata);
    host(RRD, 12'h006, 16'h0000);
    chk("unmapped", 16'h0000, rdata);
  endtask : t_regs

  task automatic t_load();
    ctrl.pulse(6'b111011, 16'h0001);
    chk("load_wait", 16'hC000, sdq);
    ctrl.pulse(6'b111111, 16'h0000);
    chk("load_ptr", 16'hC001, sdq);
    ctrl.pulse(6'b101111, 16'h0000);
    chk("adv", 16'hC002, sdq);
    chk("flag1_early", 16'h0001, 16'(eor1_n));
    ctrl.pulse(6'b101111, 16'h0000);
    chk("flag1_hit", 16'h0000, 16'(eor1_n));
    chk("flag2_apart", 16'h0001, 16'(eor2_n));
    host(RRD, 12'h004, 16'h0000);
    chk("flag_reg", 16'h0001, rdata);
    host(RWR, 12'h005, 16'h0FFE);
    chk("flag1_clr", 16'h0001, 16'(eor1_n));
  endtask : t_load

  task automatic t_seqrw();
    ctrl.pulse(6'b010111, 16'h5A5A);
    host(RD, 12'h003, 16'h0000);
    chk("seq_wr", 16'h5A5A, rdata);
    ctrl.drive_out(1'b0);
    ctrl.pulse(6'b011111, 16'h0000);
    chk("rd_on", 16'h0000, 16'(sdq_oe_n));
    chk("rd_data", 16'h5A5A, sdq);
    ctrl.drive_out(1'b1);
    chk("drv_off", 16'h0001, 16'(sdq_oe_n));
    ctrl.drive_out(1'b0);
    chk("drv_on", 16'h0000, 16'(sdq_oe_n));
    ctrl.pulse(6'b111111, 16'h0000);
    chk("port_off", 16'h0001, 16'(sdq_oe_n));
    ctrl.drive_out(1'b1);
  endtask : t_seqrw

  task automatic t_reload();
    ctrl.pulse(6'b111110, 16'h0000);
    chk("reload2", 16'hC002, sdq);
    ctrl.pulse(6'b111101, 16'h0000);
    chk("reload1", 16'hC000, sdq);
  endtask : t_reload

  task automatic t_wrap();
    ctrl.pulse(6'b111011, 16'h0FFF);
    ctrl.pulse(6'b111111, 16'h0000);
    chk("top", 16'hA511, sdq);
    ctrl.pulse(6'b101111, 16'h0000);
    chk("wrap", 16'hC000, sdq);
    ctrl.pulse(6'b101111, 16'h0000);
    chk("flag2_hit", 16'h0000, 16'(eor2_n));
    chk("flag1_apart", 16'h0001, 16'(eor1_n));
    host(RRD, 12'h004, 16'h0000);
    chk("flag_reg2", 16'h0002, rdata);
    host(RWR, 12'h005, 16'h0001);
    chk("flag2_clr", 16'h0001, 16'(eor2_n));
  endtask : t_wrap

  task automatic t_midreset();
    ctrl.pulse(6'b111110, 16'h0000);
    ctrl.pulse(6'b101111, 16'h0000);
    chk("flag1_again", 16'h0000, 16'(eor1_n));
    do_reset();
    chk("flag1_rst", 16'h0001, 16'(eor1_n));
    chk("ptr_rst", 16'hC000, sdq);
    host(RRD, 12'h001, 16'h0000);
    chk("end1_rst", 16'h0000, rdata);
  endtask : t_midreset

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    do_reset();
    t_reset();
    t_array();
    t_regs();
    t_load();
    t_seqrw();
    t_reload();
    t_wrap();
    t_midreset();
    wrap_up();
  end
endmodule : srb_buffer_test
